// ==== msc_defs.vh ====
// constants and register map of the measurement configuration keeper
`ifndef MSC_DEFS_VH
`define MSC_DEFS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define MSC_REG_FUNC 8'h00
`define MSC_REG_NAME0 8'h04
`define MSC_REG_NAME1 8'h08
`define MSC_REG_NAME2 8'h0C
`define MSC_REG_CALC 8'h10
`define MSC_REG_CMD 8'h14
`define MSC_REG_SETTING 8'h18
`define MSC_REG_STATUS 8'h1C
`define MSC_REG_DC_BASE 8'h20
`define MSC_REG_AC_BASE 8'h30
`define MSC_REG_RESULT 8'h40
`define MSC_OFS_NULL_CTRL 2'h0
`define MSC_OFS_NULL_VAL 2'h1
`define MSC_OFS_RANGE 2'h2

// ----------------------------------------
// fields
// ----------------------------------------
`define MSC_CALC_SCAL 0
`define MSC_CALC_LIM 1
`define MSC_CALC_HIST 2
`define MSC_CALC_STAT 3
`define MSC_CMD_FACTORY 0
`define MSC_CMD_PRESET 1
`define MSC_CMD_CONFIG 2
`define MSC_CMD_CFG_FUNC_LO 8
`define MSC_NULL_EN_BIT 0
`define MSC_NULL_AUTO_BIT 1
`define MSC_RANGE_AUTO_BIT 8

// ----------------------------------------
// function codes
// ----------------------------------------
`define MSC_FN_CONT 4'h0
`define MSC_FN_CURR_AC 4'h1
`define MSC_FN_CURR_DC 4'h2
`define MSC_FN_DIOD 4'h3
`define MSC_FN_FREQ 4'h4
`define MSC_FN_FRES 4'h5
`define MSC_FN_PER 4'h6
`define MSC_FN_RES 4'h7
`define MSC_FN_TEMP 4'h8
`define MSC_FN_VOLT_AC 4'h9
`define MSC_FN_VOLT_DC 4'hA
`define MSC_FN_CAP 4'hB
`define MSC_FN_COUNT 12

// ----------------------------------------
// ranges, values and reset values
// ----------------------------------------
`define MSC_RNG_200UA 3'h0
`define MSC_RNG_10A 3'h5
`define MSC_RANGE_RESET 3'h0
`define MSC_NULL_MAX 32'h00B71B00
`define MSC_NULL_MIN 32'hFF48E500
`define MSC_NULL_RESET 32'h00000000
`define MSC_OVERLOAD_CODE 32'h7FFFFFFF
`define MSC_SETTING_RESET 32'h00000000

`endif

// ==== msc_func_name.v ====
// quoted short keyword of a measurement function
`timescale 1ns/1ns
`include "msc_defs.vh"
module msc_func_name (
  input wire [3:0] func,
  output reg [95:0] name
);

  // ----------------------------------------
  // keyword lookup, left aligned, space padded
  // ----------------------------------------
  always @* begin
    case (func)
      `MSC_FN_CONT: name = "\"CONT\"      ";
      `MSC_FN_CURR_AC: name = "\"CURR:AC\"   ";
      `MSC_FN_CURR_DC: name = "\"CURR\"      ";
      `MSC_FN_DIOD: name = "\"DIOD\"      ";
      `MSC_FN_FREQ: name = "\"FREQ\"      ";
      `MSC_FN_FRES: name = "\"FRES\"      ";
      `MSC_FN_PER: name = "\"PER\"       ";
      `MSC_FN_RES: name = "\"RES\"       ";
      `MSC_FN_TEMP: name = "\"TEMP\"      ";
      `MSC_FN_VOLT_AC: name = "\"VOLT:AC\"   ";
      `MSC_FN_VOLT_DC: name = "\"VOLT\"      ";
      `MSC_FN_CAP: name = "\"CAP\"       ";
      default: name = "\"VOLT\"      ";
    endcase
  end

endmodule // msc_func_name

// ==== msc_sense_config.v ====
// measurement configuration keeper with AXI4-Lite register access
`timescale 1ns/1ns
`include "msc_defs.vh"
module msc_sense_config (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire raw_valid,
  input wire [31:0] raw_value,
  input wire raw_over_range,
  output reg result_valid,
  output reg [31:0] result_value,
  output reg result_overload,
  output reg overload_display,
  output reg [3:0] function_select,
  output reg scaling_enable,
  output reg limit_test_enable,
  output reg histogram_enable,
  output reg statistics_enable
);

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  // slot of a current function: 0 dc, 1 ac
  function cur_slot;
    input [3:0] fn;
    begin
      cur_slot = (fn == `MSC_FN_CURR_AC);
    end
  endfunction

  function is_current;
    input [3:0] fn;
    begin
      is_current = (fn == `MSC_FN_CURR_AC) || (fn == `MSC_FN_CURR_DC);
    end
  endfunction

  // per-current register window: 20..2B dc, 30..3B ac
  function cur_addr;
    input [7:0] a;
    begin
      cur_addr = (a[7:5] == 3'h1) && (a[3:2] != 2'h3);
    end
  endfunction

  function valid_func;
    input [3:0] fn;
    begin
      valid_func = (fn < 4'hC);
    end
  endfunction

  // limit a signed microampere value to twelve amperes either way
  function [31:0] clamp_null;
    input [31:0] v;
    begin
      if ($signed(v) > $signed(`MSC_NULL_MAX))
        clamp_null = `MSC_NULL_MAX;
      else if ($signed(v) < $signed(`MSC_NULL_MIN))
        clamp_null = `MSC_NULL_MIN;
      else
        clamp_null = v;
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg null_en [0:1];
  reg null_auto [0:1];
  reg [31:0] null_val [0:1];
  reg [2:0] rng_code [0:1];
  reg rng_auto [0:1];
  reg [31:0] fn_setting [0:`MSC_FN_COUNT-1];
  reg [7:0] wr_addr;
  reg aw_held;
  reg [31:0] wr_data;
  reg [3:0] wr_strb;
  reg w_held;
  reg last_over;
  wire [95:0] func_name;
  wire do_write;
  wire wr_full;
  wire wr_cur;
  wire wr_slot;
  wire [1:0] wr_field;
  wire rd_cur;
  wire rd_slot;
  wire [1:0] rd_field;
  wire [3:0] cfg_func;
  wire sel_cur;
  wire sel_slot;
  wire [31:0] nulled;
  integer i;

  msc_func_name u_name (
    .func(function_select),
    .name(func_name)
  );

  // ----------------------------------------
  // write channel capture
  // ----------------------------------------
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_full = (wr_strb == 4'hF);
  assign wr_cur = cur_addr(wr_addr);
  assign wr_slot = wr_addr[4];
  assign wr_field = wr_addr[3:2];
  assign cfg_func = wr_data[`MSC_CMD_CFG_FUNC_LO+3:`MSC_CMD_CFG_FUNC_LO];
  assign sel_cur = is_current(function_select);
  assign sel_slot = cur_slot(function_select);
  assign nulled = raw_value - null_val[sel_slot];

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (wr_addr)
          `MSC_REG_FUNC, `MSC_REG_CALC, `MSC_REG_CMD, `MSC_REG_SETTING: s_axi_bresp <= 2'h0;
          default: s_axi_bresp <= wr_cur ? 2'h0 : 2'h2;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // configuration state and measurement path
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      function_select <= `MSC_FN_VOLT_DC;
      scaling_enable <= 1'b0;
      limit_test_enable <= 1'b0;
      histogram_enable <= 1'b0;
      statistics_enable <= 1'b0;
      for (i = 0; i < 2; i = i + 1) begin
        null_en[i] <= 1'b0;
        null_auto[i] <= 1'b1;
        null_val[i] <= `MSC_NULL_RESET;
        rng_code[i] <= `MSC_RANGE_RESET;
        rng_auto[i] <= 1'b1;
      end
      for (i = 0; i < `MSC_FN_COUNT; i = i + 1)
        fn_setting[i] <= `MSC_SETTING_RESET;
      result_valid <= 1'b0;
      result_value <= 32'h00000000;
      result_overload <= 1'b0;
      overload_display <= 1'b0;
      last_over <= 1'b0;
    end else begin
      result_valid <= 1'b0;
      // readings of the selected function
      if (raw_valid) begin
        result_valid <= 1'b1;
        if (raw_over_range && !(sel_cur && rng_auto[sel_slot])) begin
          result_value <= `MSC_OVERLOAD_CODE;
          result_overload <= 1'b1;
          overload_display <= 1'b1;
          last_over <= 1'b1;
        end else begin
          result_overload <= 1'b0;
          overload_display <= 1'b0;
          last_over <= 1'b0;
          if (sel_cur && null_en[sel_slot] && null_auto[sel_slot]) begin
            null_val[sel_slot] <= clamp_null(raw_value);
            null_auto[sel_slot] <= 1'b0;
            result_value <= 32'h00000000;
          end else if (sel_cur && null_en[sel_slot]) begin
            result_value <= nulled;
          end else begin
            result_value <= raw_value;
          end
        end
      end
      // host writes; a write in the same cycle overrides a capture
      if (do_write && wr_full) begin
        if (wr_addr == `MSC_REG_FUNC) begin
          if (valid_func(wr_data[3:0]) && (wr_data[3:0] != function_select)) begin
            function_select <= wr_data[3:0];
            scaling_enable <= 1'b0;
            limit_test_enable <= 1'b0;
            histogram_enable <= 1'b0;
            statistics_enable <= 1'b0;
          end
        end else if (wr_addr == `MSC_REG_CALC) begin
          scaling_enable <= wr_data[`MSC_CALC_SCAL];
          limit_test_enable <= wr_data[`MSC_CALC_LIM];
          histogram_enable <= wr_data[`MSC_CALC_HIST];
          statistics_enable <= wr_data[`MSC_CALC_STAT];
          if (wr_data[`MSC_CALC_SCAL] && !scaling_enable && sel_cur)
            null_auto[sel_slot] <= 1'b1;
        end else if (wr_addr == `MSC_REG_SETTING) begin
          fn_setting[function_select] <= wr_data;
        end else if (wr_addr == `MSC_REG_CMD) begin
          if (wr_data[`MSC_CMD_FACTORY] || wr_data[`MSC_CMD_PRESET]) begin
            function_select <= `MSC_FN_VOLT_DC;
            scaling_enable <= 1'b0;
            limit_test_enable <= 1'b0;
            histogram_enable <= 1'b0;
            statistics_enable <= 1'b0;
            for (i = 0; i < 2; i = i + 1) begin
              null_en[i] <= 1'b0;
              null_auto[i] <= 1'b1;
              null_val[i] <= `MSC_NULL_RESET;
              rng_code[i] <= `MSC_RANGE_RESET;
              rng_auto[i] <= 1'b1;
            end
          end else if (wr_data[`MSC_CMD_CONFIG] && valid_func(cfg_func)) begin
            function_select <= cfg_func;
            scaling_enable <= 1'b0;
            limit_test_enable <= 1'b0;
            histogram_enable <= 1'b0;
            statistics_enable <= 1'b0;
            for (i = 0; i < 2; i = i + 1) begin
              null_en[i] <= 1'b0;
              null_auto[i] <= 1'b1;
              null_val[i] <= `MSC_NULL_RESET;
            end
            if (is_current(cfg_func)) begin
              rng_auto[cur_slot(cfg_func)] <= 1'b1;
              rng_code[cur_slot(cfg_func)] <= `MSC_RANGE_RESET;
            end
          end
        end else if (wr_cur) begin
          case (wr_field)
            `MSC_OFS_NULL_CTRL: begin
              null_en[wr_slot] <= wr_data[`MSC_NULL_EN_BIT];
              if (wr_data[`MSC_NULL_EN_BIT] && !null_en[wr_slot])
                null_auto[wr_slot] <= 1'b1;
              else
                null_auto[wr_slot] <= wr_data[`MSC_NULL_AUTO_BIT];
            end
            `MSC_OFS_NULL_VAL: begin
              null_val[wr_slot] <= clamp_null(wr_data);
              null_auto[wr_slot] <= 1'b0;
            end
            `MSC_OFS_RANGE: begin
              rng_auto[wr_slot] <= wr_data[`MSC_RANGE_AUTO_BIT];
              if (wr_data[2:0] <= `MSC_RNG_10A)
                rng_code[wr_slot] <= wr_data[2:0];
            end
            default: begin
              rng_auto[wr_slot] <= rng_auto[wr_slot];
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_cur = cur_addr(s_axi_araddr);
  assign rd_slot = s_axi_araddr[4];
  assign rd_field = s_axi_araddr[3:2];

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h00000000;
      if (s_axi_araddr == `MSC_REG_FUNC)
        s_axi_rdata <= {28'h0000000, function_select};
      else if (s_axi_araddr == `MSC_REG_NAME0)
        s_axi_rdata <= func_name[95:64];
      else if (s_axi_araddr == `MSC_REG_NAME1)
        s_axi_rdata <= func_name[63:32];
      else if (s_axi_araddr == `MSC_REG_NAME2)
        s_axi_rdata <= func_name[31:0];
      else if (s_axi_araddr == `MSC_REG_CALC)
        s_axi_rdata <= {28'h0000000, statistics_enable, histogram_enable,
                        limit_test_enable, scaling_enable};
      else if (s_axi_araddr == `MSC_REG_CMD)
        s_axi_rdata <= 32'h00000000;
      else if (s_axi_araddr == `MSC_REG_SETTING)
        s_axi_rdata <= fn_setting[function_select];
      else if (s_axi_araddr == `MSC_REG_STATUS)
        s_axi_rdata <= {31'h00000000, last_over};
      else if (s_axi_araddr == `MSC_REG_RESULT)
        s_axi_rdata <= result_value;
      else if (rd_cur) begin
        case (rd_field)
          `MSC_OFS_NULL_CTRL: s_axi_rdata <= {30'h00000000, null_auto[rd_slot],
                                              null_en[rd_slot]};
          `MSC_OFS_NULL_VAL: s_axi_rdata <= null_val[rd_slot];
          `MSC_OFS_RANGE: s_axi_rdata <= {23'h000000, rng_auto[rd_slot], 5'h00,
                                          rng_code[rd_slot]};
          default: s_axi_rdata <= 32'h00000000;
        endcase
      end else
        s_axi_rresp <= 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // msc_sense_config

// ==== msc_sense_config_properties.sv ====
// port assertions for the measurement configuration keeper
`timescale 1ns/1ns
module msc_sense_config_props (
  input wire aclk,
  input wire aresetn,
  input wire raw_valid,
  input wire [31:0] raw_value,
  input wire raw_over_range,
  input wire result_valid,
  input wire [31:0] result_value,
  input wire result_overload,
  input wire overload_display,
  input wire [3:0] function_select,
  input wire scaling_enable,
  input wire limit_test_enable,
  input wire histogram_enable,
  input wire statistics_enable
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  wire is_curr = function_select == 4'h1 || function_select == 4'h2;
  wire any_calc = scaling_enable || limit_test_enable || histogram_enable || statistics_enable;
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence s_reading;
    raw_valid ##1 result_valid;
  endsequence
  sequence s_over_free;
    raw_valid && raw_over_range && !is_curr;
  endsequence
  sequence s_plain;
    raw_valid && !raw_over_range && !is_curr;
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  chk_func_default: assert property ($rose(aresetn) |-> function_select == 4'hA)
    else $error("function not default after reset");
  chk_func_legal: assert property (function_select < 4'hC)
    else $error("function code out of range");
  chk_calc_clear: assert property ($changed(function_select) |-> !any_calc)
    else $error("calc enables kept over function change");
  chk_result_time: assert property (raw_valid |=> result_valid)
    else $error("no result after reading");
  chk_result_idle: assert property (!raw_valid |=> !result_valid)
    else $error("result without reading");
  chk_over_code: assert property (s_reading ##0 result_overload |->
    result_value == 32'h7FFFFFFF) else $error("overload result not overload code");
  chk_over_free: assert property (s_over_free |=> result_overload && overload_display)
    else $error("overload not flagged");
  chk_over_lamp: assert property (s_reading |-> overload_display == result_overload)
    else $error("lamp differs from result overload");
  chk_plain_value: assert property (s_plain |=>
    result_value == $past(raw_value) && !result_overload) else $error("reading altered");
endmodule // msc_sense_config_props
bind msc_sense_config msc_sense_config_props msc_sense_config_props_i (.*);

// ==== msc_host_model.sv ====
// host model: AXI4-Lite master for the register port
`timescale 1ns/1ns
module msc_host_model (
  input wire aclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // released lines show the inverse, never a stale value
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit ad = 0;
    bit dd = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        ad = 1;
        s_axi_awvalid <= 0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        dd = 1;
        s_axi_wvalid <= 0;
        s_axi_wdata <= ~d;
      end
    end
    s_axi_bready <= 1;
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    s_axi_araddr <= ~a;
    s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
endmodule // msc_host_model

// ==== tb_top.sv ====
// self-checking bench for the measurement configuration keeper
`timescale 1ns/1ns
module tb_top;
  logic aclk = 0;
  logic aresetn = 0;
  logic raw_valid = 0;
  logic [31:0] raw_value = '0;
  logic raw_over_range = 0;
  logic [2:0] s_axi_awprot = '0;
  logic [2:0] s_axi_arprot = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  wire [7:0] s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata, result_value;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  wire s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  wire result_valid, result_overload, overload_display;
  wire scaling_enable, limit_test_enable, histogram_enable, statistics_enable;
  wire [3:0] function_select;
  wire [3:0] calc = {scaling_enable, limit_test_enable, histogram_enable, statistics_enable};
  logic [7:0] base[2] = '{8'h20, 8'h30};
  string nm[12] = '{"CONT", "CURR:AC", "CURR", "DIOD", "FREQ", "FRES", "PER", "RES", "TEMP",
    "VOLT:AC", "VOLT", "CAP"};
  logic [31:0] seed = 32'h0000003F;
  logic [31:0] x1, x2, rv;
  logic [1:0] rr;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  msc_sense_config msc_sense_config_i (.*);
  msc_host_model msc_host_model_i (.*);
  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      n_fail++;
      stop_test();
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] name_word(input int f, input int w);
    string q;
    q = {"\"", nm[f], "\""};
    for (int i = 0; i < 4; i++)
      name_word = {name_word[23:0], (4 * w + i < q.len()) ? q[4 * w + i] : 8'h20};
  endfunction
  function automatic logic [31:0] exp_res(input logic [31:0] v, input logic ov, input logic nul,
    input logic [31:0] nv);
    return ov ? 32'h7FFFFFFF : nul ? v - nv : v;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    msc_host_model_i.wr(a, d, rr);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    msc_host_model_i.rd(a, rv, rr);
    chk(rv, e);
  endtask
  task fn(input logic [31:0] e);
    @(negedge aclk);
    chk(function_select, e);
  endtask
  task meas(input logic [31:0] v, input logic ov, input logic eov, input logic nul,
    input logic [31:0] nv);
    @(posedge aclk);
    raw_valid <= 1;
    raw_value <= v;
    raw_over_range <= ov;
    @(posedge aclk);
    raw_valid <= 0;
    raw_value <= ~v;
    raw_over_range <= 0;
    @(negedge aclk);
    chk(result_valid, 1);
    chk(result_value, exp_res(v, eov, nul, nv));
    chk({result_overload, overload_display}, {eov, eov});
  endtask
  task do_reset();
    aresetn <= 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1;
  endtask
  task stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    do_reset();
    rd(8'h00, 32'hA);
    foreach (base[b]) begin
      rd(base[b], 32'h2);
      rd(base[b] + 8'h4, 32'h0);
      rd(base[b] + 8'h8, 32'h100);
    end
    for (int f = 0; f < 12; f++) begin
      wr(8'h10, 32'hF);
      @(negedge aclk);
      chk(calc, 32'hF);
      wr(8'h00, 32'(f));
      fn(32'(f));
      chk(calc, 32'h0);
      for (int w = 0; w < 3; w++)
        rd(8'h04 + 8'(4 * w), name_word(f, w));
    end
    wr(8'h00, 32'hC);
    fn(32'hB);
    for (int r = 0; r < 7; r++) begin
      wr(8'h28, 32'(r));
      rd(8'h28, r < 6 ? 32'(r) : 32'h5);
    end
    wr(8'h28, 32'h100);
    x1 = rnd();
    x2 = rnd();
    wr(8'h00, 32'h2);
    wr(8'h18, x1);
    wr(8'h00, 32'h7);
    wr(8'h18, x2);
    wr(8'h00, 32'h2);
    rd(8'h18, x1);
    wr(8'h00, 32'h7);
    rd(8'h18, x2);
    foreach (base[b]) begin
      x1 = rnd() & 32'h7FFFFF;
      x2 = rnd() & 32'h7FFFFF;
      wr(8'h00, b ? 32'h1 : 32'h2);
      wr(base[b] + 8'h4, 32'h00C00000);
      rd(base[b] + 8'h4, 32'h00B71B00);
      rd(base[b], 32'h0);
      wr(base[b] + 8'h4, 32'hFF000000);
      rd(base[b] + 8'h4, 32'hFF48E500);
      wr(8'h10, 32'h1);
      rd(base[b], 32'h2);
      wr(base[b], 32'h1);
      rd(base[b], 32'h3);
      meas(x1, 0, 0, 1, x1);
      rd(base[b] + 8'h4, x1);
      rd(base[b], 32'h1);
      meas(x2, 0, 0, 1, x1);
      wr(base[b] + 8'h4, x2 >> 1);
      meas(x2, 0, 0, 1, x2 >> 1);
      wr(base[b], 32'h0);
      meas(x2, 0, 0, 0, 0);
      wr(base[b] + 8'h8, 32'h3);
      rd(base[b] + 8'h8, 32'h3);
      rd(base[1 - b] + 8'h8, 32'h100);
      meas(x2, 1, 1, 0, 0);
      rd(8'h40, 32'h7FFFFFFF);
      rd(8'h1C, 32'h1);
      wr(base[b] + 8'h8, 32'h100);
      meas(x2, 1, 0, 0, 0);
      rd(8'h1C, 32'h0);
    end
    wr(8'h00, 32'hA);
    repeat (16) begin
      x1 = rnd();
      meas(x1, x1[0], x1[0], 0, 0);
    end
    for (int c = 0; c < 3; c++) begin
      wr(8'h00, 32'h1);
      wr(8'h34, 32'h5);
      wr(8'h30, 32'h1);
      wr(8'h38, 32'h2);
      wr(8'h14, c == 2 ? 32'h104 : 32'(1 << c));
      rd(8'h30, 32'h2);
      rd(8'h34, 32'h0);
      rd(8'h38, 32'h100);
      if (c < 2)
        fn(32'hA);
    end
    msc_host_model_i.rd(8'h80, rv, rr);
    chk(rr, 32'h2);
    chk(rv, 32'h0);
    msc_host_model_i.wr(8'h80, 32'h1, rr);
    chk(rr, 32'h2);
    wr(8'h00, 32'h3);
    do_reset();
    fn(32'hA);
    rd(8'h20, 32'h2);
    stop_test();
  end
endmodule // tb_top
